/* logic/rxeim_pkg.sv */
// constants for the receiver error interrupt mask block
package rxeim_pkg;
    // =========================================================
    // register map
    localparam logic [6:0] RX_ERROR_FLAGS_ADDR = 7'h18;
    localparam logic [6:0] RX_ERROR_MASK_ADDR  = 7'h19;
    localparam logic [7:0] MASK_RESET          = 8'h00;
    localparam logic [7:0] ZERO_BYTE           = 8'h00;
    // =========================================================
    // bit positions of flags and of their enables
    localparam int BIT_VALID     = 7;
    localparam int BIT_EMPHASIS  = 6;
    localparam int BIT_NONAUDIO  = 5;
    localparam int BIT_PREAMBLE  = 4;
    localparam int BIT_CHAN_CHK  = 3;
    localparam int BIT_ABSENT    = 2;
    localparam int BIT_BIPHASE   = 1;
    localparam int BIT_LOCK      = 0;
    localparam int FLAG_COUNT    = 8;
    // error flags that latch until read; the rest follow their source
    localparam logic [7:0] STICKY_FLAGS = 8'h0A;
endpackage

/* logic/rxeim_flag_if.sv */
// bundle between the flag tracker and the register logic
`timescale 1ns/1ps
interface rxeim_flag_if;
    logic [7:0] raw;
    logic       clr;
    logic [7:0] flag;
    logic [7:0] pending;
    modport tracker (input raw, input clr, output flag, output pending);
    modport owner   (output raw, output clr, input flag, input pending);
endinterface

/* logic/rxeim_flag_track.sv */
// per-flag state and change-event tracking for the receiver flags
`timescale 1ns/1ps
module rxeim_flag_track (
    input  wire logic         clk,
    input  wire logic         reset_n,
    rxeim_flag_if.tracker     fl
);
    logic [7:0] flag;
    logic [7:0] pending;
    logic [7:0] next_flag;
    logic [7:0] next_pending;
    logic [7:0] event_now;

    // =========================================================
    // per-bit next state
    genvar b;
    generate
        for (b = 0; b < rxeim_pkg::FLAG_COUNT; b++) begin : g_bit
            always_comb begin
                if (rxeim_pkg::STICKY_FLAGS[b]) begin
                    // error latches until the flag register is read
                    event_now[b] = fl.raw[b] && !flag[b];
                    next_flag[b] = fl.raw[b] || (flag[b] && !fl.clr);
                end else begin
                    // after a read, only a change of state raises again
                    event_now[b] = fl.raw[b] != flag[b];
                    next_flag[b] = fl.raw[b];
                end
                // new event wins over a clear in the same cycle
                next_pending[b] = event_now[b] || (pending[b] && !fl.clr);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag    <= rxeim_pkg::ZERO_BYTE;
            pending <= rxeim_pkg::ZERO_BYTE;
        end else begin
            flag    <= next_flag;
            pending <= next_pending;
        end
    end

    assign fl.flag    = flag;
    assign fl.pending = pending;

    preamble_event_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fl.raw[rxeim_pkg::BIT_PREAMBLE] != flag[rxeim_pkg::BIT_PREAMBLE])
        |=> pending[rxeim_pkg::BIT_PREAMBLE])
        else $error("preamble change did not set pending");
    preamble_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fl.clr && fl.raw[rxeim_pkg::BIT_PREAMBLE] == flag[rxeim_pkg::BIT_PREAMBLE])
        |=> !pending[rxeim_pkg::BIT_PREAMBLE])
        else $error("preamble pending without change");
endmodule // rxeim_flag_track

/* logic/rxeim_mask.sv */
// receiver error interrupt mask register and gated interrupt output
`timescale 1ns/1ps
module rxeim_mask (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [6:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       received_valid_flag,
    input  wire logic       emphasis_flag,
    input  wire logic       nonaudio_flag,
    input  wire logic       preamble_nonaudio_flag,
    input  wire logic       chan_status_check_fail,
    input  wire logic       input_absent_flag,
    input  wire logic       biphase_parity_flag,
    input  wire logic       lock_flag,
    output logic            rx_error_irq
);
    // =========================================================
    // flag tracking
    rxeim_flag_if fl ();

    assign fl.raw = {received_valid_flag, emphasis_flag, nonaudio_flag,
                     preamble_nonaudio_flag, chan_status_check_fail,
                     input_absent_flag, biphase_parity_flag, lock_flag};
    // reading the flag register acknowledges all pending events
    assign fl.clr = reg_rd && (reg_addr == rxeim_pkg::RX_ERROR_FLAGS_ADDR);

    rxeim_flag_track u_track (
        .clk     (clk),
        .reset_n (reset_n),
        .fl      (fl)
    );

    // =========================================================
    // mask register, readback, interrupt
    logic [7:0] receiver_error_interrupt_mask;
    logic [7:0] next_mask;
    logic [7:0] next_rdata;
    logic [7:0] gated;
    logic       next_irq;

    always_comb begin
        next_mask = receiver_error_interrupt_mask;
        if (reg_wr && reg_addr == rxeim_pkg::RX_ERROR_MASK_ADDR) begin
            next_mask = reg_wdata;
        end
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                rxeim_pkg::RX_ERROR_FLAGS_ADDR: next_rdata = fl.flag;
                rxeim_pkg::RX_ERROR_MASK_ADDR:  next_rdata = receiver_error_interrupt_mask;
                default:                        next_rdata = rxeim_pkg::ZERO_BYTE;
            endcase
        end
        // each mask bit gates its own flag
        gated    = fl.pending & receiver_error_interrupt_mask;
        next_irq = |gated;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            receiver_error_interrupt_mask <= rxeim_pkg::MASK_RESET;
            reg_rdata                     <= rxeim_pkg::ZERO_BYTE;
            rx_error_irq                  <= 1'b0;
        end else begin
            receiver_error_interrupt_mask <= next_mask;
            reg_rdata                     <= next_rdata;
            rx_error_irq                  <= next_irq;
        end
    end

    // =========================================================
    // checks
    sequence s_mask_write(logic [7:0] v);
        reg_wr && reg_addr == rxeim_pkg::RX_ERROR_MASK_ADDR && reg_wdata == v;
    endsequence

    valid_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        fl.pending[rxeim_pkg::BIT_VALID] && receiver_error_interrupt_mask[rxeim_pkg::BIT_VALID]
        |=> rx_error_irq) else $error("validity enabled but no irq");
    emph_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        fl.pending[rxeim_pkg::BIT_EMPHASIS]
        && receiver_error_interrupt_mask[rxeim_pkg::BIT_EMPHASIS]
        |=> rx_error_irq) else $error("emphasis enabled but no irq");
    nonaudio_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        fl.pending[rxeim_pkg::BIT_NONAUDIO]
        && receiver_error_interrupt_mask[rxeim_pkg::BIT_NONAUDIO]
        |=> rx_error_irq) else $error("non-audio enabled but no irq");
    preamble_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        fl.pending == 8'h10 && !receiver_error_interrupt_mask[rxeim_pkg::BIT_PREAMBLE]
        |=> !rx_error_irq) else $error("masked preamble raised irq");
    check_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        fl.pending[rxeim_pkg::BIT_CHAN_CHK]
        && receiver_error_interrupt_mask[rxeim_pkg::BIT_CHAN_CHK]
        |=> rx_error_irq) else $error("check error enabled but no irq");
    absent_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        fl.pending == 8'h04 && !receiver_error_interrupt_mask[rxeim_pkg::BIT_ABSENT]
        |=> !rx_error_irq) else $error("masked absent flag raised irq");
    biphase_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_mask_write(8'h02) ##1 (fl.pending[rxeim_pkg::BIT_BIPHASE] && !reg_wr)
        |=> rx_error_irq) else $error("biphase enabled but no irq");
    lock_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_mask_write(8'hFE) ##1 (fl.pending == 8'h01 && !reg_wr)
        |=> !rx_error_irq) else $error("masked lock raised irq");
    irq_or_a: assert property (@(posedge clk) disable iff (!reset_n)
        rx_error_irq == $past(|(fl.pending & receiver_error_interrupt_mask)))
        else $error("irq differs from gated pending OR");
endmodule // rxeim_mask

/* verif/tb.sv */
// self-checking testbench for the receiver error interrupt mask block
`timescale 1ns/1ps
module tb;
    logic       clk;
    logic       reset_n;
    logic [6:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] raw;
    logic       rx_error_irq;
    logic [7:0] rv;
    int         error_cnt;
    int         comparisons;

    rxeim_mask dut_u (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .received_valid_flag(raw[7]), .emphasis_flag(raw[6]), .nonaudio_flag(raw[5]),
        .preamble_nonaudio_flag(raw[4]), .chan_status_check_fail(raw[3]),
        .input_absent_flag(raw[2]), .biphase_parity_flag(raw[1]), .lock_flag(raw[0]),
        .rx_error_irq(rx_error_irq));

    // =========================================================
    // shared tasks
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // read data lands at the read edge, so sample just after it
    task automatic rd(input logic [6:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // bounded wait for the interrupt; a miss ends the run
    task automatic wait_irq(input string m);
        for (int k = 0; k < 5; k++) begin
            cyc(1);
            if (rx_error_irq === 1'b1) return;
        end
        chk(1'b0, m);
        summarize();
    endtask
    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic regs_test();
        rd(rxeim_pkg::RX_ERROR_MASK_ADDR);
        chk(rv === rxeim_pkg::MASK_RESET, "mask reset value");
        wr(rxeim_pkg::RX_ERROR_MASK_ADDR, 8'hA5);
        wr(rxeim_pkg::RX_ERROR_FLAGS_ADDR, 8'h5A);
        rd(rxeim_pkg::RX_ERROR_MASK_ADDR);
        chk(rv === 8'hA5, "mask readback");
        rd(7'h05);
        chk(rv === 8'h00, "unmapped read");
        cyc(3);
        chk(rx_error_irq === 1'b0, "irq with nothing pending");
        wr(rxeim_pkg::RX_ERROR_MASK_ADDR, 8'h00);
    endtask
    // masked flag stays quiet, unmasking raises it, read clears it
    task automatic gate_test(input int i);
        logic sticky;
        sticky = rxeim_pkg::STICKY_FLAGS[i];
        @(posedge clk) raw[i] <= 1'b1;
        cyc(4);
        chk(rx_error_irq === 1'b0, "masked flag raised irq");
        wr(rxeim_pkg::RX_ERROR_MASK_ADDR, 8'h01 << i);
        wait_irq("enabled flag gave no irq");
        if (sticky) @(posedge clk) raw[i] <= 1'b0;
        rd(rxeim_pkg::RX_ERROR_FLAGS_ADDR);
        chk(rv[i] === 1'b1, "flag readback");
        cyc(3);
        chk(rx_error_irq === 1'b0, "irq held after clearing read");
        if (!sticky) begin
            @(posedge clk) raw[i] <= 1'b0;
            wait_irq("state change gave no irq");
            rd(rxeim_pkg::RX_ERROR_FLAGS_ADDR);
            cyc(3);
        end
        wr(rxeim_pkg::RX_ERROR_MASK_ADDR, 8'hFF);
        cyc(3);
        chk(rx_error_irq === 1'b0, "stale pending after read");
        wr(rxeim_pkg::RX_ERROR_MASK_ADDR, 8'h00);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        error_cnt   = 0;
        comparisons = 0;
        reset_n     = 1'b0;
        reg_addr    = 7'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        reg_wdata   = 8'h00;
        raw         = 8'h00;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        regs_test();
        for (int i = 0; i < rxeim_pkg::FLAG_COUNT; i++) gate_test(i);
        summarize();
    end
endmodule // tb
